// file: rtl/fcu_bus_engine.sv
module fcu_bus_engine #(
  parameter int AW = 19
) (
  // Clock and reset
  input logic clk,
  input logic rstn,
  // Cycle request
  fcu_cyc_if.engine cyc,
  // Flash pins
  output logic [AW-1:0] fl_addr,
  output logic [7:0] fl_dq_o,
  input logic [7:0] fl_dq_i,
  output logic fl_dq_oe_n,
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n
);
  import fcu_pkg::*;

  typedef enum logic [2:0] {
    EN_IDLE = 3'b000,
    EN_SET = 3'b001,
    EN_ACT = 3'b010,
    EN_REL = 3'b011,
    EN_GAP = 3'b100
  } fcu_en_state_e;

  fcu_en_state_e state_q, state_d;
  logic [7:0] cnt_q, cnt_d;
  logic wr_q, wr_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [7:0] dq_o_q, dq_o_d;
  logic dq_oe_n_q, dq_oe_n_d;
  logic ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] s1_q, s2_q, s3_q;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    wr_d = wr_q;
    addr_d = addr_q;
    dq_o_d = dq_o_q;
    dq_oe_n_d = dq_oe_n_q;
    ce_n_d = ce_n_q;
    oe_n_d = oe_n_q;
    we_n_d = we_n_q;
    rdata_d = rdata_q;
    case (state_q)
      EN_IDLE: begin
        if (cyc.req) begin
          // Address and data settle before any strobe falls [RULE19]
          addr_d = cyc.addr;
          wr_d = cyc.wr;
          dq_o_d = cyc.wdata;
          dq_oe_n_d = ~cyc.wr;
          ce_n_d = 1'b0;
          state_d = EN_SET;
        end
      end
      EN_SET: begin
        // Never both strobes low together [RULE17]
        if (wr_q) begin
          we_n_d = 1'b0;
          cnt_d = WP_CYC - 8'h01;
        end else begin
          oe_n_d = 1'b0;
          cnt_d = ACC_CYC - 8'h01;
        end
        state_d = EN_ACT;
      end
      EN_ACT: begin
        if (cnt_q != 8'h00) begin
          cnt_d = cnt_q - 8'h01;
        end else if (wr_q) begin
          we_n_d = 1'b1;
          state_d = EN_REL;
        end else if (s2_q == s3_q) begin
          rdata_d = s3_q;
          oe_n_d = 1'b1;
          state_d = EN_REL;
        end
      end
      EN_REL: begin
        // Data held one cycle past the rising write strobe [RULE19]
        ce_n_d = 1'b1;
        dq_oe_n_d = 1'b1;
        cnt_d = HZ_CYC - 8'h01;
        state_d = EN_GAP;
      end
      EN_GAP: begin
        if (cnt_q != 8'h00) begin
          cnt_d = cnt_q - 8'h01;
        end else begin
          state_d = EN_IDLE;
        end
      end
      default: begin
        state_d = EN_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= EN_IDLE;
      cnt_q <= 8'h00;
      wr_q <= 1'b0;
      addr_q <= '0;
      dq_o_q <= 8'h00;
      dq_oe_n_q <= 1'b1;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      rdata_q <= 8'h00;
      s1_q <= 8'h00;
      s2_q <= 8'h00;
      s3_q <= 8'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      dq_o_q <= dq_o_d;
      dq_oe_n_q <= dq_oe_n_d;
      ce_n_q <= ce_n_d;
      oe_n_q <= oe_n_d;
      we_n_q <= we_n_d;
      rdata_q <= rdata_d;
      s1_q <= fl_dq_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign cyc.done = (state_q == EN_GAP) && (cnt_q == 8'h00);
  assign cyc.rdata = rdata_q;
  assign fl_addr = addr_q;
  assign fl_dq_o = dq_o_q;
  assign fl_dq_oe_n = dq_oe_n_q;
  assign fl_ce_n = ce_n_q;
  assign fl_oe_n = oe_n_q;
  assign fl_we_n = we_n_q;

  ////////////////////////////////////////////////////////////////////////////
  a_strobe_excl: assert property (@(posedge clk) disable iff (!rstn) !(!oe_n_q && !we_n_q)) // [RULE17]
    else $error("output and write strobes low together");
  a_we_needs_ce: assert property (@(posedge clk) disable iff (!rstn) !we_n_q |-> !ce_n_q) // [RULE15]
    else $error("write strobe low without chip select");
  a_read_no_drive: assert property (@(posedge clk) disable iff (!rstn) !oe_n_q |-> dq_oe_n_q) // [RULE14]
    else $error("host drives data during a read");
  a_we_pulse_len: assert property (@(posedge clk) disable iff (!rstn)
    $fell(we_n_q) |-> (!we_n_q && !dq_oe_n_q)[*8] ##1 (!we_n_q && !dq_oe_n_q)[*2] ##1 ($rose(we_n_q) && !dq_oe_n_q)) // [RULE19]
    else $error("write pulse or data hold wrong");
endmodule

// file: rtl/fcu_cyc_if.sv
interface fcu_cyc_if #(parameter int AW = 19);
  logic req;
  logic wr;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;

  modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
  modport engine (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// file: rtl/fcu_flash_host.sv
// Notes on behaviour
// (RULE1) Program and erase always need unlock writes
// (RULE2) Program: AA, 55, A0, then address/data
// (RULE3) Erase: six writes, two unlock pairs
// (RULE4) Sector erase ends with 30 at sector
// (RULE5) Chip erase ends with 10 at 5555
// (RULE6) Device drops bad sequences back to read
// (RULE7) Only address bits 14..0 matter for commands
// (RULE8) Identification entry: AA, 55, 90
// (RULE9) Identification reads give maker and part codes
// (RULE10) Exit: single F0, or AA, 55, F0
// (RULE11) Exit returns device to array read
// (RULE12) Exit ignored while device busy
// (RULE13) Identification mode lost over power-down
// (RULE14) Data pins float unless read enabled
// (RULE15) Device acts only with chip select low
// (RULE16) Device latches write data internally
// (RULE17) No write with output strobe low
// (RULE18) Commands ignored while program or erase runs
// (RULE19) Address at later fall, data at earlier rise
// (RULE20) Tracker restarts after abort or completion
// (RULE21) Unlock writes issued back to back
module fcu_flash_host #(
  parameter int AW = 19
) (
  // Clock and reset
  input logic clk,
  input logic rstn,
  // Command port
  input logic cmd_valid,
  output logic cmd_ready,
  input fcu_pkg::fcu_op_e cmd_op,
  input logic [AW-1:0] cmd_addr,
  input logic [7:0] cmd_data,
  // Response port
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  // Flash pins
  output logic [AW-1:0] fl_addr,
  output logic [7:0] fl_dq_o,
  input logic [7:0] fl_dq_i,
  output logic fl_dq_oe_n,
  output logic fl_ce_n,
  output logic fl_oe_n,
  output logic fl_we_n
);
  import fcu_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ISSUE = 3'b001,
    ST_WAIT = 3'b010,
    ST_POLL = 3'b011,
    ST_PWAIT = 3'b100,
    ST_RESP = 3'b101
  } fcu_state_e;

  fcu_state_e state_q, state_d;
  fcu_op_e op_q, op_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [7:0] data_q, data_d;
  logic [2:0] idx_q, idx_d;
  logic prev_ok_q, prev_ok_d;
  logic prev_bit_q, prev_bit_d;
  logic [7:0] rsp_data_q, rsp_data_d;

  fcu_cyc_if #(.AW(AW)) cyc ();

  ////////////////////////////////////////////////////////////////////////////
  // Sequence tables
  function automatic logic [2:0] step_count(input fcu_op_e op);
    case (op)
      OP_READ: step_count = 3'd1;
      OP_PROG: step_count = 3'd4;
      OP_SECT: step_count = 3'd6;
      OP_CHIP: step_count = 3'd6;
      OP_ID_EXIT1: step_count = 3'd1;
      default: step_count = 3'd3;
    endcase
  endfunction

  // Command addresses carry zeros above bit 14 [RULE7]
  function automatic logic [AW-1:0] cmd_word(input logic [14:0] a);
    cmd_word = {{(AW-CMD_AW){1'b0}}, a};
  endfunction

  function automatic logic [AW-1:0] step_addr(input fcu_op_e op, input logic [2:0] idx,
                                              input logic [AW-1:0] ua);
    if (op == OP_READ || op == OP_ID_EXIT1) begin
      step_addr = ua;
    end else begin
      case (idx)
        3'd1: step_addr = cmd_word(ADDR_UNLK2);
        3'd3: step_addr = (op == OP_PROG) ? ua : cmd_word(ADDR_UNLK1); // [RULE2]
        3'd4: step_addr = cmd_word(ADDR_UNLK2);
        3'd5: step_addr = (op == OP_SECT) ? ua : cmd_word(ADDR_UNLK1); // [RULE4] [RULE5]
        default: step_addr = cmd_word(ADDR_UNLK1);
      endcase
    end
  endfunction

  function automatic logic [7:0] step_data(input fcu_op_e op, input logic [2:0] idx,
                                           input logic [7:0] ud);
    if (op == OP_ID_EXIT1) begin
      step_data = DAT_ID_EXIT; // [RULE10]
    end else begin
      case (idx)
        3'd0: step_data = DAT_UNLK1; // [RULE1]
        3'd1: step_data = DAT_UNLK2;
        3'd2: begin
          case (op)
            OP_PROG: step_data = DAT_PROG; // [RULE2]
            OP_ID_ENTER: step_data = DAT_ID_ENTER; // [RULE8]
            OP_ID_EXIT3: step_data = DAT_ID_EXIT; // [RULE10]
            default: step_data = DAT_ERASE; // [RULE3]
          endcase
        end
        3'd3: step_data = (op == OP_PROG) ? ud : DAT_UNLK1; // [RULE3]
        3'd4: step_data = DAT_UNLK2;
        default: step_data = (op == OP_SECT) ? DAT_SECT : DAT_CHIP; // [RULE4] [RULE5]
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    addr_d = addr_q;
    data_d = data_q;
    idx_d = idx_q;
    prev_ok_d = prev_ok_q;
    prev_bit_d = prev_bit_q;
    rsp_data_d = rsp_data_q;
    case (state_q)
      ST_IDLE: begin
        if (cmd_valid) begin
          op_d = cmd_op;
          addr_d = cmd_addr;
          data_d = cmd_data;
          idx_d = 3'd0;
          state_d = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (cyc.done) begin
          if (op_q == OP_READ) begin
            rsp_data_d = cyc.rdata;
            state_d = ST_RESP;
          end else if (idx_q + 3'd1 == step_count(op_q)) begin
            rsp_data_d = 8'h00;
            prev_ok_d = 1'b0;
            // Busy after program or erase: poll until the toggle bit settles
            if (op_q == OP_PROG || op_q == OP_SECT || op_q == OP_CHIP) begin
              state_d = ST_POLL;
            end else begin
              state_d = ST_RESP;
            end
          end else begin
            // Next unlock write follows at once [RULE21]
            idx_d = idx_q + 3'd1;
            state_d = ST_ISSUE;
          end
        end
      end
      ST_POLL: begin
        state_d = ST_PWAIT;
      end
      ST_PWAIT: begin
        if (cyc.done) begin
          prev_ok_d = 1'b1;
          prev_bit_d = cyc.rdata[TOGGLE_BIT];
          if (prev_ok_q && prev_bit_q == cyc.rdata[TOGGLE_BIT]) begin
            rsp_data_d = cyc.rdata;
            state_d = ST_RESP;
          end else begin
            state_d = ST_POLL;
          end
        end
      end
      ST_RESP: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      op_q <= OP_READ;
      addr_q <= '0;
      data_q <= 8'h00;
      idx_q <= 3'd0;
      prev_ok_q <= 1'b0;
      prev_bit_q <= 1'b0;
      rsp_data_q <= 8'h00;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      addr_q <= addr_d;
      data_q <= data_d;
      idx_q <= idx_d;
      prev_ok_q <= prev_ok_d;
      prev_bit_q <= prev_bit_d;
      rsp_data_q <= rsp_data_d;
    end
  end

  // No command taken while a step or a poll is in flight [RULE12] [RULE18]
  assign cmd_ready = (state_q == ST_IDLE);
  assign rsp_valid = (state_q == ST_RESP);
  assign rsp_data = rsp_data_q;

  assign cyc.req = (state_q == ST_ISSUE) || (state_q == ST_POLL);
  assign cyc.wr = (state_q == ST_ISSUE) && (op_q != OP_READ);
  assign cyc.addr = (state_q == ST_POLL) ? addr_q : step_addr(op_q, idx_q, addr_q);
  assign cyc.wdata = step_data(op_q, idx_q, data_q);

  fcu_bus_engine #(.AW(AW)) u_engine (
    .clk(clk),
    .rstn(rstn),
    .cyc(cyc),
    .fl_addr(fl_addr),
    .fl_dq_o(fl_dq_o),
    .fl_dq_i(fl_dq_i),
    .fl_dq_oe_n(fl_dq_oe_n),
    .fl_ce_n(fl_ce_n),
    .fl_oe_n(fl_oe_n),
    .fl_we_n(fl_we_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  a_first_unlock: assert property (@(posedge clk) disable iff (!rstn) // [RULE1]
    cyc.req && cyc.wr && idx_q == 3'd0 && op_q != OP_ID_EXIT1
    |-> cyc.addr[14:0] == ADDR_UNLK1 && cyc.wdata == DAT_UNLK1)
    else $error("first unlock write wrong");
  a_second_unlock: assert property (@(posedge clk) disable iff (!rstn) // [RULE3]
    cyc.req && (idx_q == 3'd1 || idx_q == 3'd4) |-> cyc.addr == cmd_word(ADDR_UNLK2) && cyc.wdata == DAT_UNLK2)
    else $error("second unlock write wrong");
  a_prog_seq: assert property (@(posedge clk) disable iff (!rstn) // [RULE2]
    cyc.req && state_q == ST_ISSUE && op_q == OP_PROG && idx_q == 3'd3
    |-> cyc.addr == addr_q && cyc.wdata == data_q && cyc.wr)
    else $error("program data write wrong");
  a_sect_final: assert property (@(posedge clk) disable iff (!rstn) // [RULE4]
    cyc.req && op_q == OP_SECT && idx_q == 3'd5 |-> cyc.addr == addr_q && cyc.wdata == DAT_SECT)
    else $error("sector erase final write wrong");
  a_chip_final: assert property (@(posedge clk) disable iff (!rstn) // [RULE5]
    cyc.req && state_q == ST_ISSUE && op_q == OP_CHIP && idx_q == 3'd5
    |-> cyc.addr == cmd_word(ADDR_UNLK1) && cyc.wdata == DAT_CHIP)
    else $error("chip erase final write wrong");
  a_id_entry: assert property (@(posedge clk) disable iff (!rstn) // [RULE8]
    cyc.req && op_q == OP_ID_ENTER && idx_q == 3'd2 |-> cyc.wdata == DAT_ID_ENTER)
    else $error("identification entry code wrong");
  a_id_exit: assert property (@(posedge clk) disable iff (!rstn) // [RULE10]
    cyc.req && op_q == OP_ID_EXIT1 |-> cyc.wdata == DAT_ID_EXIT && cyc.wr)
    else $error("identification exit code wrong");
  a_back_to_back: assert property (@(posedge clk) disable iff (!rstn) // [RULE21]
    state_q == ST_WAIT && cyc.done && op_q != OP_READ && idx_q + 3'd1 < step_count(op_q)
    |=> cyc.req && cyc.wr)
    else $error("gap between unlock writes");
  a_busy_closed: assert property (@(posedge clk) disable iff (!rstn) // [RULE18]
    state_q == ST_POLL |-> !cmd_ready ##1 !cmd_ready)
    else $error("command taken while busy");

  c_program: cover property (@(posedge clk) disable iff (!rstn) rsp_valid && op_q == OP_PROG);
  c_sect: cover property (@(posedge clk) disable iff (!rstn) rsp_valid && op_q == OP_SECT);
  c_id_entry: cover property (@(posedge clk) disable iff (!rstn) rsp_valid && op_q == OP_ID_ENTER);
  c_read: cover property (@(posedge clk) disable iff (!rstn) rsp_valid && op_q == OP_READ);
endmodule

// file: rtl/fcu_pkg.sv
package fcu_pkg;

  // Clock and pin timing
  localparam int CLK_NS = 4;
  localparam int T_WP_NS = 40;
  localparam int T_ACC_NS = 70;
  localparam int T_HZ_NS = 25;
  localparam logic [7:0] WP_CYC = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] ACC_CYC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] HZ_CYC = 8'((T_HZ_NS + CLK_NS - 1) / CLK_NS);

  // Command cycle addresses, low 15 bits only
  localparam int CMD_AW = 15;
  localparam logic [14:0] ADDR_UNLK1 = 15'h5555;
  localparam logic [14:0] ADDR_UNLK2 = 15'h2AAA;

  // Command data bytes
  localparam logic [7:0] DAT_UNLK1 = 8'hAA;
  localparam logic [7:0] DAT_UNLK2 = 8'h55;
  localparam logic [7:0] DAT_PROG = 8'hA0;
  localparam logic [7:0] DAT_ERASE = 8'h80;
  localparam logic [7:0] DAT_SECT = 8'h30;
  localparam logic [7:0] DAT_CHIP = 8'h10;
  localparam logic [7:0] DAT_ID_ENTER = 8'h90;
  localparam logic [7:0] DAT_ID_EXIT = 8'hF0;

  // Polling status bit that toggles while busy
  localparam int TOGGLE_BIT = 6;

  typedef enum logic [2:0] {
    OP_READ = 3'b000,
    OP_PROG = 3'b001,
    OP_SECT = 3'b010,
    OP_CHIP = 3'b011,
    OP_ID_ENTER = 3'b100,
    OP_ID_EXIT1 = 3'b101,
    OP_ID_EXIT3 = 3'b110
  } fcu_op_e;

endpackage

// file: tb/fcu_flash_model.sv
module fcu_flash_model #(
  parameter int AW = 19,
  parameter logic [7:0] MAKER_ID = 8'h3C, // Arbitrary value
  parameter logic [7:0] PART_ID = 8'h4D, // Arbitrary value
  parameter int BUSY_READS = 3
) (
  // Pins from host
  input wire logic [AW-1:0] fl_addr,
  input wire logic [7:0] fl_dq_o,
  input wire logic fl_dq_oe_n,
  input wire logic fl_ce_n,
  input wire logic fl_oe_n,
  input wire logic fl_we_n,
  // Data pins as seen by host
  output logic [7:0] fl_dq_i,
  // Monitor counts
  output int n_bad,
  output int n_abort,
  output int n_cmd
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] mem [int];
  logic [AW-1:0] a_lat = '0;
  logic [7:0] d_lat = 8'h00;
  logic [7:0] drv = 8'h00;
  logic idm = 1'b0;
  logic tog = 1'b0;
  logic stat = 1'b0;
  logic rd_on = 1'b0;
  int step = 0;
  int busy = 0;
  initial n_bad = 0;
  initial n_abort = 0;
  initial n_cmd = 0;

  function automatic logic [7:0] rd(input logic [AW-1:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 8'hFF;
  endfunction

  function automatic logic hit(input logic [7:0] d, input logic [14:0] a);
    return d_lat == d && a_lat[14:0] == a;
  endfunction

  task automatic fin(input int b);
    step = 0;
    busy = b;
    n_cmd++;
  endtask

  ////////////////////////////////////////////////////////////////
  // Write cycles
  always @(negedge fl_we_n) begin
    if (!fl_ce_n) begin
      a_lat = fl_addr;
      if (!fl_oe_n || fl_dq_oe_n) n_bad++;
    end
  end

  always @(posedge fl_we_n) begin
    if (!fl_ce_n) begin
      d_lat = fl_dq_o;
      if (busy > 0) n_bad++;
      else if (step == 0 && d_lat == 8'hF0) begin
        idm = 1'b0;
        fin(0);
      end else begin
        case (step)
          0, 3: step = hit(8'hAA, 15'h5555) ? step + 1 : -1;
          1, 4: step = hit(8'h55, 15'h2AAA) ? step + 1 : -1;
          2: begin
            if (hit(8'hA0, 15'h5555)) step = 9;
            else if (hit(8'h80, 15'h5555)) step = 3;
            else if (hit(8'h90, 15'h5555)) begin
              idm = 1'b1;
              fin(0);
            end else if (hit(8'hF0, 15'h5555)) begin
              idm = 1'b0;
              fin(0);
            end else step = -1;
          end
          5: begin
            if (d_lat == 8'h30) begin
              for (int k = int'(a_lat) & ~32'hFFF; k < (int'(a_lat) | 32'hFFF) + 1; k++)
                if (mem.exists(k)) mem.delete(k);
              fin(BUSY_READS);
            end else if (hit(8'h10, 15'h5555)) begin
              mem.delete();
              fin(BUSY_READS);
            end else step = -1;
          end
          default: begin
            mem[int'(a_lat)] = rd(a_lat) & d_lat;
            fin(BUSY_READS);
          end
        endcase
        if (step < 0) begin
          n_abort++;
          step = 0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read cycles, toggling status while busy
  always @(negedge fl_oe_n) begin
    if (!fl_ce_n && !fl_dq_oe_n) n_bad++;
    stat = busy > 0;
    if (stat) begin
      tog = ~tog;
      busy--;
    end
  end

  always @(fl_ce_n or fl_oe_n or fl_we_n or fl_addr or stat or tog or idm) begin
    if (!fl_ce_n && !fl_oe_n && fl_we_n) begin
      rd_on = 1'b1;
      if (stat) drv = {1'b0, tog, 6'h00};
      else if (idm && fl_addr[AW-1:1] == '0) drv = fl_addr[0] ? PART_ID : MAKER_ID;
      else drv = rd(fl_addr);
    end else if (rd_on) begin
      // Released pins show no stale value
      rd_on = 1'b0;
      drv = ~drv;
    end
  end

  assign fl_dq_i = (fl_dq_oe_n === 1'b0) ? fl_dq_o : drv;
endmodule

// file: tb/tb.sv
module tb import fcu_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int AW = 19;
  localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value
  localparam logic [7:0] PART = 8'h4D; // Arbitrary value
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic cmd_valid = 1'b0;
  fcu_op_e cmd_op = OP_READ;
  logic [AW-1:0] cmd_addr = '0;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ready, rsp_valid, fl_dq_oe_n, fl_ce_n, fl_oe_n, fl_we_n;
  logic [7:0] rsp_data, fl_dq_o, fl_dq_i;
  logic [AW-1:0] fl_addr;
  int n_bad, n_abort, n_cmd;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [15:0] seed = 16'h004A;
  logic [7:0] shadow [int];

  fcu_flash_host #(.AW(AW)) i_dut (.clk, .rstn, .cmd_valid, .cmd_ready, .cmd_op, .cmd_addr, .cmd_data,
    .rsp_valid, .rsp_data, .fl_addr, .fl_dq_o, .fl_dq_i, .fl_dq_oe_n, .fl_ce_n, .fl_oe_n, .fl_we_n);
  fcu_flash_model #(.AW(AW), .MAKER_ID(MAKER), .PART_ID(PART)) i_mem (.fl_addr, .fl_dq_o, .fl_dq_oe_n,
    .fl_ce_n, .fl_oe_n, .fl_we_n, .fl_dq_i, .n_bad, .n_abort, .n_cmd);

  initial forever #2 clk = ~clk;

  ////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [7:0] exp_rd(input logic [AW-1:0] a);
    return shadow.exists(int'(a)) ? shadow[int'(a)] : 8'hFF;
  endfunction

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic run_cmd(input fcu_op_e op, input logic [AW-1:0] a, input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
    r = rsp_data;
    @(posedge clk);
    #1;
  endtask

  task automatic prog(input logic [AW-1:0] a, input logic [7:0] d);
    logic [7:0] r;
    run_cmd(OP_PROG, a, d, r);
    shadow[int'(a)] = exp_rd(a) & d;
  endtask

  task automatic chk_rd(input logic [AW-1:0] a, input logic [7:0] exp, input string what);
    logic [7:0] r;
    run_cmd(OP_READ, a, 8'h00, r);
    chk(r, exp, what);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [AW-1:0] a, b;
    logic [7:0] d, r;
    repeat (16) @(posedge clk);
    #1;
    rstn = 1'b1;
    @(posedge clk);
    #1;
    chk({fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe_n, cmd_ready, rsp_valid, 2'b00}, 8'hF8, "idle pins");
    // Random program and read-back, a corner at the top address and a reprogram
    b = '0;
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      a = {seed[2:0], seed};
      seed = lfsr(seed);
      d = seed[7:0];
      if (k == 0) a = '1;
      if (k == 1) b = a;
      if (k == 7) a = b;
      prog(a, d);
      chk_rd(a, exp_rd(a), "program readback");
      chk(8'(n_cmd), 8'(k + 1), "completed commands");
    end
    // Sector erase spares the neighbour sector
    a = {7'h55, 12'h123};
    b = {7'h56, 12'h000};
    prog(a, 8'h5A);
    prog(b, 8'hA5);
    run_cmd(OP_SECT, {7'h55, 12'hABC}, 8'h00, r);
    for (int k = 32'h55000; k < 32'h56000; k++)
      if (shadow.exists(k)) shadow.delete(k);
    chk_rd(a, 8'hFF, "sector erased");
    chk_rd(b, 8'hA5, "sector kept");
    // Identification entry, both exits
    prog(19'h00000, 8'h12);
    prog(19'h00001, 8'h34);
    run_cmd(OP_ID_ENTER, '0, 8'h00, r);
    chk_rd(19'h00000, MAKER, "maker code");
    chk_rd(19'h00001, PART, "part code");
    chk_rd(19'h40001, exp_rd(19'h40001), "array in id mode");
    run_cmd(OP_ID_EXIT1, 19'h7BCDE, 8'h00, r);
    chk_rd(19'h00000, 8'h12, "array after short exit");
    run_cmd(OP_ID_ENTER, '0, 8'h00, r);
    chk_rd(19'h00001, PART, "part code again");
    run_cmd(OP_ID_EXIT3, '0, 8'h00, r);
    chk_rd(19'h00001, 8'h34, "array after long exit");
    // Chip erase
    run_cmd(OP_CHIP, 19'h05555, 8'h00, r);
    shadow.delete();
    chk_rd(b, 8'hFF, "chip erased");
    chk_rd(19'h00001, 8'hFF, "chip erased low");
    chk(8'(n_abort), 8'h00, "aborted sequences");
    chk(8'(n_bad), 8'h00, "pin protocol");
    print_verdict();
  end
endmodule
